/* File: verilog/svwd_defs.svh */
// constants for the supervisor watchdog and fault-output block
// assumes a 50 MHz sys_clk; included by bare name
`ifndef SVWD_DEFS_SVH
`define SVWD_DEFS_SVH

// ----------------------------------------
// clock, timebase and watchdog pulse width
// ----------------------------------------
`define SVWD_CLK_MHZ 50
`define SVWD_CLK_NS 20
`define SVWD_TICK_US 5
`define SVWD_TICK_CYCLES (`SVWD_TICK_US * `SVWD_CLK_MHZ)
`define SVWD_TICKS(us) ((us + `SVWD_TICK_US - 1) / `SVWD_TICK_US)
`define SVWD_PULSE_NS 2000
`define SVWD_PULSE_CYCLES (`SVWD_PULSE_NS / `SVWD_CLK_NS)

// ----------------------------------------
// release delays, microseconds
// ----------------------------------------
`define SVWD_REL0_US 25
`define SVWD_REL1_US 1560
`define SVWD_REL2_US 6250
`define SVWD_REL3_US 25000
`define SVWD_REL4_US 50000
`define SVWD_REL5_US 200000
`define SVWD_REL6_US 400000
`define SVWD_REL7_US 1600000

// ----------------------------------------
// watchdog periods, microseconds
// ----------------------------------------
`define SVWD_WD0_US 6250
`define SVWD_WD1_US 25000
`define SVWD_WD2_US 100000
`define SVWD_WD3_US 400000
`define SVWD_WD4_US 1600000
`define SVWD_WD5_US 6400
`define SVWD_WD6_US 25600000
`define SVWD_WD7_US 102400000

// ----------------------------------------
// register offsets
// ----------------------------------------
`define SVWD_ADDR_SF_DEP 8'h13
`define SVWD_ADDR_SF_CFG 8'h14
`define SVWD_ADDR_WD_CFG 8'h15
`define SVWD_ADDR_PRI_FLAGS 8'h28
`define SVWD_ADDR_SEC_FLAGS 8'h29
`define SVWD_ADDR_OUT_FLAGS 8'h2a
`define SVWD_ADDR_IRQ_STAT 8'h30
`define SVWD_ADDR_IRQ_MASK 8'h31

// ----------------------------------------
// field positions
// ----------------------------------------
`define SVWD_DEP_MR 0
`define SVWD_DEP_RST 1
`define SVWD_TYPE_BIT 0
`define SVWD_DLY_LSB 1
`define SVWD_WD_INIT_LSB 1
`define SVWD_WD_NORM_LSB 4
`define SVWD_WD_EN 7
`define SVWD_EV_SF 0
`define SVWD_EV_RST 1
`define SVWD_EV_WDO 7

// ----------------------------------------
// reset values and first-read invalid data
// ----------------------------------------
`define SVWD_RST_SF_DEP 8'h01
`define SVWD_RST_SF_CFG 8'h00
`define SVWD_RST_WD_CFG 8'h00
`define SVWD_RST_MASK 8'h00
`define SVWD_INVALID_DATA 8'hff

`endif

/* File: verilog/svwd_pkg.sv */
// types shared by the supervisor watchdog block
// assumes nothing beyond a SystemVerilog compiler
package svwd_pkg;
   typedef logic [7:0] svwd_byte_t;
   typedef logic [24:0] svwd_ticks_t;
   typedef enum logic [2:0] {
      WD_OFF,
      WD_INIT,
      WD_NORMAL,
      WD_PULSE,
      WD_LATCH
   } svwd_wd_state_e;
endpackage

/* File: verilog/svwd_top.sv */
// supply-fault output, watchdog timer and clear-on-read fault flags
// assumes comparator, reset-output and config inputs on sys_clk; pins synchronised here
`timescale 1ns/1ps
`default_nettype none
`include "svwd_defs.svh"

// Notes on behaviour
// R1: supply-fault output stays low for release delay after all causes clear.
// R2: config bit 0 picks open-drain (1) or weak pullup (0) for supply-fault output.
// R3: dependency bits: 0 manual reset, 1 reset output, 2..7 secondary inputs one..six.
// R4: supply-fault output releases only when every selected condition is good.
// R5: with no dependency selected the supply-fault output stays asserted.
// R6: release delay code bits 3:1 select 25us up to 1600ms.
// R7: watchdog output active low; bit 0 picks open-drain or weak pullup.
// R8: initial period in bits 3:1, normal period in bits 6:4, shared encoding.
// R9: initial period after power-up, reset events, enabling and each expiry.
// R10: normal period follows initial; processor must toggle kick input each period.
// R11: any edge on kick input restarts the count for the current period.
// R12: watchdog config bit 7 enables the timer.
// R13: with reset linked to watchdog, expiry gives a short pulse under 5us.
// R14: without reset link, expiry holds output low until a kick edge.
// R15: volatile read-only fault flags at 28h to 2Ah, cleared at power-up.
// R16: reading a flag register clears all its flags.
// R17: first flag read after power-up returns invalid data.
// R18: event flags: bit 0 supply fault, bit 1 reset, bit 7 watchdog asserted.
module svwd_top #(
   parameter int TICK_CYC = `SVWD_TICK_CYCLES // cycles per 5us timebase tick
) (
   input wire logic sys_clk, // 50 MHz clock
   input wire logic rstn, // synchronous reset, active low
   input wire svwd_pkg::svwd_byte_t addr, // register address
   input wire svwd_pkg::svwd_byte_t wdata, // write data
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   output svwd_pkg::svwd_byte_t rdata, // read data, cycle after rd
   output logic irq, // level interrupt
   input wire logic manual_reset_input_n, // manual reset pin, active low
   input wire logic watchdog_kick_input, // kick pin from processor
   input wire logic reset_output_n, // device reset output state, active low
   input wire logic reset_wdo_link, // reset output depends on watchdog output
   input wire logic [5:0] primary_fault, // primary undervoltage of inputs one..six
   input wire logic [5:0] secondary_fault, // secondary threshold fault, inputs one..six
   output logic supply_fault_output_n, // supply-fault output level, active low
   output logic supply_fault_output_oe, // high while driving pin low
   output logic supply_fault_pullup_en, // internal weak pullup on
   output logic watchdog_output_n, // watchdog output level, active low
   output logic watchdog_output_oe, // high while driving pin low
   output logic watchdog_pullup_en // internal weak pullup on
);
   import svwd_pkg::*;

   // ----------------------------------------
   // functions
   // ----------------------------------------
   function automatic svwd_ticks_t rel_ticks(input logic [2:0] code);
      case (code)
         3'h0: rel_ticks = 25'(`SVWD_TICKS(`SVWD_REL0_US)); // R6
         3'h1: rel_ticks = 25'(`SVWD_TICKS(`SVWD_REL1_US));
         3'h2: rel_ticks = 25'(`SVWD_TICKS(`SVWD_REL2_US));
         3'h3: rel_ticks = 25'(`SVWD_TICKS(`SVWD_REL3_US));
         3'h4: rel_ticks = 25'(`SVWD_TICKS(`SVWD_REL4_US));
         3'h5: rel_ticks = 25'(`SVWD_TICKS(`SVWD_REL5_US));
         3'h6: rel_ticks = 25'(`SVWD_TICKS(`SVWD_REL6_US));
         default: rel_ticks = 25'(`SVWD_TICKS(`SVWD_REL7_US));
      endcase
   endfunction

   function automatic svwd_ticks_t wd_ticks(input logic [2:0] code);
      case (code)
         3'h0: wd_ticks = 25'(`SVWD_TICKS(`SVWD_WD0_US)); // R8
         3'h1: wd_ticks = 25'(`SVWD_TICKS(`SVWD_WD1_US));
         3'h2: wd_ticks = 25'(`SVWD_TICKS(`SVWD_WD2_US));
         3'h3: wd_ticks = 25'(`SVWD_TICKS(`SVWD_WD3_US));
         3'h4: wd_ticks = 25'(`SVWD_TICKS(`SVWD_WD4_US));
         3'h5: wd_ticks = 25'(`SVWD_TICKS(`SVWD_WD5_US));
         3'h6: wd_ticks = 25'(`SVWD_TICKS(`SVWD_WD6_US));
         default: wd_ticks = 25'(`SVWD_TICKS(`SVWD_WD7_US));
      endcase
   endfunction

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   svwd_byte_t sf_dep_q;
   svwd_byte_t sf_cfg_q;
   svwd_byte_t wd_cfg_q;
   svwd_byte_t pri_q;
   svwd_byte_t sec_q;
   svwd_byte_t out_q;
   svwd_byte_t stat_q;
   svwd_byte_t mask_q;
   svwd_byte_t ev_vec;
   logic first_done_q;
   logic mr_s1_q, mr_s2_q;
   logic kick_s1_q, kick_s2_q, kick_s3_q;
   logic kick_edge;
   logic [15:0] pre_q;
   logic tick;
   logic sf_cause;
   logic sf_n_d;
   svwd_ticks_t sf_cnt_q;
   svwd_wd_state_e wd_st_q;
   svwd_ticks_t wd_cnt_q;
   logic [6:0] pulse_q;
   logic wdo_assert;
   logic rst_prev_q;
   logic rd_flags;
   logic clr_pri, clr_sec, clr_out;

   // ----------------------------------------
   // pin synchronisers and timebase
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         mr_s1_q <= 1'b1;
         mr_s2_q <= 1'b1;
         kick_s1_q <= 1'b0;
         kick_s2_q <= 1'b0;
         kick_s3_q <= 1'b0;
      end else begin
         mr_s1_q <= manual_reset_input_n;
         mr_s2_q <= mr_s1_q;
         kick_s1_q <= watchdog_kick_input;
         kick_s2_q <= kick_s1_q;
         kick_s3_q <= kick_s2_q;
      end
   end

   assign kick_edge = kick_s2_q ^ kick_s3_q; // R11

   always_ff @(posedge sys_clk) begin
      if (!rstn || tick) begin
         pre_q <= 16'h0000;
      end else begin
         pre_q <= pre_q + 16'h0001;
      end
   end

   assign tick = (pre_q == 16'(TICK_CYC - 1));

   // ----------------------------------------
   // supply-fault output
   // ----------------------------------------
   always_comb begin
      sf_cause = (sf_dep_q == 8'h00); // R5
      sf_cause = sf_cause | (sf_dep_q[`SVWD_DEP_MR] & ~mr_s2_q); // R3
      sf_cause = sf_cause | (sf_dep_q[`SVWD_DEP_RST] & ~reset_output_n); // R3
      sf_cause = sf_cause | (|(sf_dep_q[7:2] & secondary_fault)); // R3 R4
   end

   always_comb begin
      sf_n_d = supply_fault_output_n;
      if (sf_cause) begin
         sf_n_d = 1'b0;
      end else if (!supply_fault_output_n && sf_cnt_q == 25'h0000000) begin
         sf_n_d = 1'b1; // R1 R4
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         sf_cnt_q <= 25'(`SVWD_TICKS(`SVWD_REL0_US)); // R1
      end else if (sf_cause) begin
         sf_cnt_q <= rel_ticks(sf_cfg_q[3:1]); // R1 R6
      end else if (tick && sf_cnt_q != 25'h0000000) begin
         sf_cnt_q <= sf_cnt_q - 25'h0000001; // R1
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         supply_fault_output_n <= 1'b0;
         supply_fault_output_oe <= 1'b1;
         supply_fault_pullup_en <= 1'b1;
      end else begin
         supply_fault_output_n <= sf_n_d;
         supply_fault_output_oe <= ~sf_n_d;
         supply_fault_pullup_en <= ~sf_cfg_q[`SVWD_TYPE_BIT]; // R2
      end
   end

   // ----------------------------------------
   // watchdog timer
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         wd_st_q <= WD_OFF;
         wd_cnt_q <= 25'h0000000;
         pulse_q <= 7'h00;
      end else if (!wd_cfg_q[`SVWD_WD_EN]) begin
         wd_st_q <= WD_OFF; // R12
      end else begin
         case (wd_st_q)
            WD_OFF: begin
               wd_st_q <= WD_INIT; // R9
               wd_cnt_q <= wd_ticks(wd_cfg_q[3:1]);
            end
            WD_INIT, WD_NORMAL: begin
               if (!reset_output_n) begin
                  wd_st_q <= WD_INIT; // R9
                  wd_cnt_q <= wd_ticks(wd_cfg_q[3:1]);
               end else if (kick_edge) begin
                  wd_st_q <= WD_NORMAL; // R10 R11
                  wd_cnt_q <= wd_ticks(wd_cfg_q[6:4]);
               end else if (tick) begin
                  if (wd_cnt_q == 25'h0000000) begin
                     if (reset_wdo_link) begin
                        wd_st_q <= WD_PULSE; // R13
                        pulse_q <= 7'(`SVWD_PULSE_CYCLES - 1);
                     end else begin
                        wd_st_q <= WD_LATCH; // R14
                     end
                  end else begin
                     wd_cnt_q <= wd_cnt_q - 25'h0000001;
                  end
               end
            end
            WD_PULSE: begin
               if (pulse_q == 7'h00) begin
                  wd_st_q <= WD_INIT; // R9 R13
                  wd_cnt_q <= wd_ticks(wd_cfg_q[3:1]);
               end else begin
                  pulse_q <= pulse_q - 7'h01;
               end
            end
            WD_LATCH: begin
               if (kick_edge) begin
                  wd_st_q <= WD_INIT; // R14 R9
                  wd_cnt_q <= wd_ticks(wd_cfg_q[3:1]);
               end
            end
            default: begin
               wd_st_q <= WD_OFF;
            end
         endcase
      end
   end

   assign wdo_assert = (wd_st_q == WD_PULSE) || (wd_st_q == WD_LATCH);

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         watchdog_output_n <= 1'b1;
         watchdog_output_oe <= 1'b0;
         watchdog_pullup_en <= 1'b1;
      end else begin
         watchdog_output_n <= ~wdo_assert; // R7
         watchdog_output_oe <= wdo_assert;
         watchdog_pullup_en <= ~wd_cfg_q[`SVWD_TYPE_BIT]; // R7
      end
   end

   // ----------------------------------------
   // output events
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         rst_prev_q <= 1'b1;
      end else begin
         rst_prev_q <= reset_output_n;
      end
   end

   always_comb begin
      ev_vec = 8'h00;
      ev_vec[`SVWD_EV_SF] = supply_fault_output_n & ~sf_n_d; // R18
      ev_vec[`SVWD_EV_RST] = rst_prev_q & ~reset_output_n; // R18
      ev_vec[`SVWD_EV_WDO] = watchdog_output_n & wdo_assert; // R18
   end

   // ----------------------------------------
   // fault flags, clear on read
   // ----------------------------------------
   assign rd_flags = rd && (addr == `SVWD_ADDR_PRI_FLAGS || addr == `SVWD_ADDR_SEC_FLAGS
                            || addr == `SVWD_ADDR_OUT_FLAGS);
   assign clr_pri = rd && first_done_q && addr == `SVWD_ADDR_PRI_FLAGS; // R16 R17
   assign clr_sec = rd && first_done_q && addr == `SVWD_ADDR_SEC_FLAGS;
   assign clr_out = rd && first_done_q && addr == `SVWD_ADDR_OUT_FLAGS;

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         first_done_q <= 1'b0; // R17
      end else if (rd_flags) begin
         first_done_q <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         pri_q <= 8'h00; // R15
         sec_q <= 8'h00;
         out_q <= 8'h00;
      end else begin
         pri_q <= (clr_pri ? 8'h00 : pri_q) | {2'h0, primary_fault}; // R16
         sec_q <= (clr_sec ? 8'h00 : sec_q) | {2'h0, secondary_fault}; // R16
         out_q <= (clr_out ? 8'h00 : out_q) | ev_vec; // R16 R18
      end
   end

   // ----------------------------------------
   // configuration and interrupt registers
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         sf_dep_q <= `SVWD_RST_SF_DEP;
         sf_cfg_q <= `SVWD_RST_SF_CFG;
         wd_cfg_q <= `SVWD_RST_WD_CFG;
         mask_q <= `SVWD_RST_MASK;
      end else if (wr) begin
         if (addr == `SVWD_ADDR_SF_DEP) begin
            sf_dep_q <= wdata; // R3
         end else if (addr == `SVWD_ADDR_SF_CFG) begin
            sf_cfg_q <= {4'h0, wdata[3:0]}; // R2 R6
         end else if (addr == `SVWD_ADDR_WD_CFG) begin
            wd_cfg_q <= wdata; // R8 R12
         end else if (addr == `SVWD_ADDR_IRQ_MASK) begin
            mask_q <= wdata;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         stat_q <= 8'h00;
      end else if (wr && addr == `SVWD_ADDR_IRQ_STAT) begin
         stat_q <= (stat_q & ~wdata) | ev_vec;
      end else begin
         stat_q <= stat_q | ev_vec;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(stat_q & mask_q);
      end
   end

   // ----------------------------------------
   // read data
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         rdata <= 8'h00;
      end else if (rd) begin
         if (addr == `SVWD_ADDR_SF_DEP) begin
            rdata <= sf_dep_q;
         end else if (addr == `SVWD_ADDR_SF_CFG) begin
            rdata <= sf_cfg_q;
         end else if (addr == `SVWD_ADDR_WD_CFG) begin
            rdata <= wd_cfg_q;
         end else if (rd_flags && !first_done_q) begin
            rdata <= `SVWD_INVALID_DATA; // R17
         end else if (addr == `SVWD_ADDR_PRI_FLAGS) begin
            rdata <= pri_q; // R15
         end else if (addr == `SVWD_ADDR_SEC_FLAGS) begin
            rdata <= sec_q;
         end else if (addr == `SVWD_ADDR_OUT_FLAGS) begin
            rdata <= out_q;
         end else if (addr == `SVWD_ADDR_IRQ_STAT) begin
            rdata <= stat_q;
         end else if (addr == `SVWD_ADDR_IRQ_MASK) begin
            rdata <= mask_q;
         end else begin
            rdata <= 8'h00;
         end
      end
   end

endmodule // svwd_top

`default_nettype wire

/* File: tb/svwd_sva.sv */
// checker for the supply-fault and watchdog outputs
// assumes binding onto svwd_top with its TICK_CYC
`timescale 1ns/1ps
`default_nettype none
`include "svwd_defs.svh"
module svwd_sva #(
   parameter int TICK_CYC = 250 // clocks per tick
) (
   input wire logic sys_clk, // clock
   input wire logic rstn, // reset
   input wire svwd_pkg::svwd_byte_t addr, // address
   input wire svwd_pkg::svwd_byte_t wdata, // data
   input wire logic wr, // write
   input wire logic reset_wdo_link, // pulse mode
   input wire logic watchdog_kick_input, // kick pin
   input wire logic supply_fault_output_n, // fault out
   input wire logic supply_fault_output_oe, // drive
   input wire logic supply_fault_pullup_en, // pullup
   input wire logic watchdog_output_n, // wd out
   input wire logic watchdog_output_oe, // drive
   input wire logic watchdog_pullup_en // pullup
);
   import svwd_pkg::*;
   logic [7:0] wd_low_q;
   logic [11:0] sf_low_q;
   logic [3:0] age_q;
   logic kick_q;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // ----
   // run lengths
   // ----
   always_ff @(posedge sys_clk) begin
      if (!rstn || watchdog_output_n) begin
         wd_low_q <= 8'h00;
      end else if (wd_low_q != 8'hff) begin
         wd_low_q <= wd_low_q + 8'h01;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (!rstn || supply_fault_output_n) begin
         sf_low_q <= 12'h000;
      end else if (sf_low_q != 12'hfff) begin
         sf_low_q <= sf_low_q + 12'h001;
      end
   end
   // cycles since the kick pin last changed
   always_ff @(posedge sys_clk) begin
      kick_q <= watchdog_kick_input;
      if (!rstn || kick_q != watchdog_kick_input) begin
         age_q <= 4'h0;
      end else if (age_q != 4'hf) begin
         age_q <= age_q + 4'h1;
      end
   end
   // ----
   // properties
   // ----
   sf_drive_a: assert property (supply_fault_output_oe == !supply_fault_output_n)
      else $error("fault drive differs from level");
   wd_drive_a: assert property (watchdog_output_oe == !watchdog_output_n)
      else $error("watchdog drive differs from level");
   sf_type_a: assert property (wr && addr == `SVWD_ADDR_SF_CFG |=> ##1
      supply_fault_pullup_en == !$past(wdata[0], 2)) else $error("fault pullup wrong");
   wd_type_a: assert property (wr && addr == `SVWD_ADDR_WD_CFG |=> ##1
      watchdog_pullup_en == !$past(wdata[0], 2)) else $error("watchdog pullup wrong");
   no_dep_a: assert property (wr && addr == `SVWD_ADDR_SF_DEP && wdata == 8'h00
      |=> ##1 (!supply_fault_output_n) [*4]) else $error("fault released without cause");
   sf_hold_a: assert property ($rose(supply_fault_output_n)
      |-> sf_low_q >= 12'(4 * TICK_CYC)) else $error("fault released too soon");
   pulse_len_a: assert property ($rose(watchdog_output_n) && reset_wdo_link
      |-> wd_low_q == `SVWD_PULSE_CYCLES) else $error("watchdog pulse width wrong");
   latch_end_a: assert property ($rose(watchdog_output_n) && !reset_wdo_link
      |-> age_q < 4'h8 || $past(wr, 2) || $past(wr, 3)) else $error("latch left early");
   wd_off_a: assert property (wr && addr == `SVWD_ADDR_WD_CFG && !wdata[`SVWD_WD_EN]
      |=> ##2 watchdog_output_n [*4]) else $error("disabled watchdog asserted");
endmodule // svwd_sva
bind svwd_top svwd_sva #(.TICK_CYC(TICK_CYC)) u_sva (.sys_clk(sys_clk), .rstn(rstn),
   .addr(addr), .wdata(wdata), .wr(wr), .reset_wdo_link(reset_wdo_link),
   .watchdog_kick_input(watchdog_kick_input),
   .supply_fault_output_n(supply_fault_output_n),
   .supply_fault_output_oe(supply_fault_output_oe),
   .supply_fault_pullup_en(supply_fault_pullup_en),
   .watchdog_output_n(watchdog_output_n), .watchdog_output_oe(watchdog_output_oe),
   .watchdog_pullup_en(watchdog_pullup_en));
`default_nettype wire

/* File: tb/svwd_proc_model.sv */
// processor model: toggles the kick pin on request, sees the watchdog pin
// assumes sys_clk shared with the block; pin pulled high when released
`timescale 1ns/1ps
`default_nettype none
module svwd_proc_model (
   input wire logic sys_clk, // clock
   input wire logic kick_now, // request one kick edge
   input wire logic wdo_oe, // block pulls pin low
   output logic watchdog_kick_input, // kick pin
   output logic wdo_pin // pin level seen
);
   // ----
   // kick and pin
   // ----
   initial watchdog_kick_input = 1'b0;
   always @(posedge sys_clk) begin
      if (kick_now) begin
         watchdog_kick_input <= !watchdog_kick_input;
      end
   end
   assign wdo_pin = !wdo_oe;
endmodule // svwd_proc_model
`default_nettype wire

/* File: tb/test_svwd_top.sv */
// self-checking bench for the supervisor watchdog block
// assumes TICK_CYC of 2, so a 5us tick lasts two clocks
`timescale 1ns/1ps
`default_nettype none
`include "svwd_defs.svh"
module test_svwd_top;
   import svwd_pkg::*;
   localparam int TK = 2;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   svwd_byte_t addr = 8'h00;
   svwd_byte_t wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic mr_n = 1'b1;
   logic rst_out_n = 1'b1;
   logic link = 1'b0;
   logic [5:0] pri = 6'h00;
   logic [5:0] sec = 6'h00;
   logic kick_now = 1'b0;
   svwd_byte_t rdata;
   logic irq;
   logic sf_n;
   logic sf_pu;
   logic wdo_oe;
   logic wdo_pu;
   logic kick;
   logic wdo_pin;
   int miscompares = 0;
   int comparisons = 0;
   // ----
   // harness
   // ----
   always #10 sys_clk = ~sys_clk;
   svwd_top #(.TICK_CYC(TK)) uut (.sys_clk(sys_clk), .rstn(rstn), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
      .manual_reset_input_n(mr_n), .watchdog_kick_input(kick),
      .reset_output_n(rst_out_n), .reset_wdo_link(link), .primary_fault(pri),
      .secondary_fault(sec), .supply_fault_output_n(sf_n), .supply_fault_output_oe(),
      .supply_fault_pullup_en(sf_pu), .watchdog_output_n(), .watchdog_output_oe(wdo_oe),
      .watchdog_pullup_en(wdo_pu));
   svwd_proc_model pm (.sys_clk(sys_clk), .kick_now(kick_now), .wdo_oe(wdo_oe),
      .watchdog_kick_input(kick), .wdo_pin(wdo_pin));
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input svwd_byte_t a, input svwd_byte_t d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      cyc(1);
      wr <= 1'b0;
      cyc(1);
   endtask
   task automatic rd_chk(input svwd_byte_t a, input svwd_byte_t e);
      addr <= a;
      rd <= 1'b1;
      cyc(1);
      rd <= 1'b0;
      #1 chk(rdata, e);
      cyc(1);
   endtask
   task automatic kick1;
      kick_now <= 1'b1;
      cyc(1);
      kick_now <= 1'b0;
   endtask
   // ----
   // scenarios
   // ----
   task automatic t_flags;
      rd_chk(`SVWD_ADDR_PRI_FLAGS, `SVWD_INVALID_DATA);
      pri <= 6'h24;
      cyc(1);
      pri <= 6'h00;
      cyc(2);
      rd_chk(`SVWD_ADDR_PRI_FLAGS, 8'h24);
      rd_chk(`SVWD_ADDR_PRI_FLAGS, 8'h00);
      wr_reg(`SVWD_ADDR_PRI_FLAGS, 8'hff);
      rd_chk(`SVWD_ADDR_PRI_FLAGS, 8'h00);
   endtask
   task automatic t_regs;
      wr_reg(`SVWD_ADDR_SF_CFG, 8'hff);
      cyc(1);
      chk({7'h0, sf_pu}, 8'h00);
      rd_chk(`SVWD_ADDR_SF_CFG, 8'h0f);
      wr_reg(`SVWD_ADDR_WD_CFG, 8'h7f);
      cyc(1);
      chk({7'h0, wdo_pu}, 8'h00);
      rd_chk(`SVWD_ADDR_WD_CFG, 8'h7f);
      wr_reg(`SVWD_ADDR_WD_CFG, 8'h00);
      cyc(1);
      chk({7'h0, wdo_pu}, 8'h01);
      wr_reg(`SVWD_ADDR_SF_DEP, 8'hfc);
      rd_chk(`SVWD_ADDR_SF_DEP, 8'hfc);
      rd_chk(8'h40, 8'h00);
   endtask
   task automatic t_sf;
      int us[3] = '{25, 1560, 6250};
      wr_reg(`SVWD_ADDR_SF_CFG, 8'h00);
      wr_reg(`SVWD_ADDR_SF_DEP, 8'h00);
      cyc(4);
      chk({7'h0, sf_n}, 8'h00);
      wr_reg(`SVWD_ADDR_SF_DEP, 8'h03);
      cyc(24);
      chk({7'h0, sf_n}, 8'h01);
      mr_n <= 1'b0;
      cyc(6);
      chk({7'h0, sf_n}, 8'h00);
      mr_n <= 1'b1;
      rst_out_n <= 1'b0;
      cyc(20);
      chk({7'h0, sf_n}, 8'h00);
      rst_out_n <= 1'b1;
      rd_chk(`SVWD_ADDR_OUT_FLAGS, 8'h03);
      wr_reg(`SVWD_ADDR_SF_DEP, 8'h0c);
      for (int c = 0; c < 3; c++) begin
         wr_reg(`SVWD_ADDR_SF_CFG, 8'(c << 1));
         sec <= 6'h03;
         cyc(4);
         chk({7'h0, sf_n}, 8'h00);
         sec <= 6'h01;
         cyc(us[c] / 2 + 8);
         chk({7'h0, sf_n}, 8'h00);
         sec <= 6'h00;
         cyc(((us[c] + 4) / 5) * TK - 4);
         chk({7'h0, sf_n}, 8'h00);
         cyc(10);
         chk({7'h0, sf_n}, 8'h01);
      end
      rd_chk(`SVWD_ADDR_SEC_FLAGS, 8'h03);
   endtask
   task automatic t_irq;
      wr_reg(`SVWD_ADDR_SF_CFG, 8'h00);
      wr_reg(`SVWD_ADDR_SF_DEP, 8'h01);
      wr_reg(`SVWD_ADDR_IRQ_STAT, 8'hff);
      wr_reg(`SVWD_ADDR_IRQ_MASK, 8'h01);
      chk({7'h0, irq}, 8'h00);
      mr_n <= 1'b0;
      cyc(8);
      chk({7'h0, irq}, 8'h01);
      mr_n <= 1'b1;
      wr_reg(`SVWD_ADDR_IRQ_STAT, 8'h01);
      cyc(1);
      chk({7'h0, irq}, 8'h00);
      wr_reg(`SVWD_ADDR_IRQ_MASK, 8'h00);
      cyc(30);
      mr_n <= 1'b0;
      cyc(8);
      chk({7'h0, irq}, 8'h00);
      rd_chk(`SVWD_ADDR_IRQ_STAT, 8'h01);
      mr_n <= 1'b1;
   endtask
   task automatic t_wd_latch;
      rd_chk(`SVWD_ADDR_OUT_FLAGS, 8'h01);
      link <= 1'b0;
      wr_reg(`SVWD_ADDR_WD_CFG, 8'hd0);
      cyc(2480);
      chk({7'h0, wdo_pin}, 8'h01);
      cyc(40);
      chk({7'h0, wdo_pin}, 8'h00);
      cyc(200);
      chk({7'h0, wdo_pin}, 8'h00);
      kick1();
      cyc(8);
      chk({7'h0, wdo_pin}, 8'h01);
      repeat (4) begin
         kick1();
         cyc(2000);
         chk({7'h0, wdo_pin}, 8'h01);
      end
      cyc(530);
      chk({7'h0, wdo_pin}, 8'h01);
      cyc(50);
      chk({7'h0, wdo_pin}, 8'h00);
      kick1();
      wr_reg(`SVWD_ADDR_WD_CFG, 8'h50);
      cyc(3000);
      chk({7'h0, wdo_pin}, 8'h01);
      rd_chk(`SVWD_ADDR_OUT_FLAGS, 8'h80);
   endtask
   task automatic t_wd_pulse;
      link <= 1'b1;
      wr_reg(`SVWD_ADDR_WD_CFG, 8'hd0);
      cyc(2000);
      rst_out_n <= 1'b0;
      cyc(2);
      rst_out_n <= 1'b1;
      cyc(2480);
      chk({7'h0, wdo_pin}, 8'h01);
      cyc(60);
      chk({7'h0, wdo_pin}, 8'h00);
      cyc(100);
      chk({7'h0, wdo_pin}, 8'h01);
      wr_reg(`SVWD_ADDR_WD_CFG, 8'h50);
      rd_chk(`SVWD_ADDR_OUT_FLAGS, 8'h82);
   endtask
   task automatic summarize;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      cyc(4);
      rstn <= 1'b1;
      cyc(2);
      t_flags();
      t_regs();
      t_sf();
      t_irq();
      t_wd_latch();
      t_wd_pulse();
      summarize();
   end
   initial begin
      cyc(40000);
      miscompares++;
      summarize();
   end
endmodule // test_svwd_top
`default_nettype wire
